// ==== hw/arsc_core.sv ====
`default_nettype none
module arsc_core #(
    parameter int CONV_CYCLES = arsc_pkg::CONV_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [2:0] i_clk_ratio,
    input wire logic [1:0] i_scan_mode,
    input wire logic i_double_trig,
    input wire logic i_add_mode,
    input wire logic [2:0] i_add_count,
    input wire logic i_start,
    input wire arsc_pkg::arsc_req_s i_req,
    output logic o_busy,
    output logic o_sample,
    output logic [arsc_pkg::CH_W-1:0] o_mux_chan,
    output logic [1:0] o_mux_src,
    input wire logic [arsc_pkg::RES_W-1:0] i_sar_data,
    output logic o_done,
    output logic o_double_ok,
    input wire logic [1:0] i_rd_src,
    input wire logic [arsc_pkg::CH_W-1:0] i_rd_chan,
    input wire logic i_rd_dup,
    output arsc_pkg::arsc_rd_s o_rd
);
    // ***************************************************************
    // parameter check
    // ***************************************************************
    // the step counter is CNT_W bits wide and the last step is one below the count
    if (CONV_CYCLES < 2 || CONV_CYCLES > 63) begin : g_bad_conv
        $error("CONV_CYCLES out of range");
    end

    // ***************************************************************
    // conversion clock enable from bus clock ratio
    // ***************************************************************
    // the core runs in the bus domain; faster conversion clocks are modelled as one tick per bus cycle
    logic [2:0] div_q, div_d;
    logic tick;
    arsc_pkg::arsc_state_e st_q, st_d;

    function automatic logic [2:0] ratio_top(input logic [2:0] r);
        unique case (r)
            arsc_pkg::RATIO_2_1: ratio_top = 3'h1;
            arsc_pkg::RATIO_4_1: ratio_top = 3'h3;
            arsc_pkg::RATIO_8_1: ratio_top = 3'h7;
            default: ratio_top = 3'h0;          // 1:1 and 1:2 step every bus cycle
        endcase
    endfunction

    // divider next value; held at zero outside a conversion so every run takes the same span
    always_comb begin
        tick = (div_q >= ratio_top(i_clk_ratio));
        div_d = (tick || st_q != arsc_pkg::ARSC_CONV) ? 3'h0 : div_q + 3'h1;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_d;
        end
    end

    // ***************************************************************
    // conversion sequencer
    // ***************************************************************
    logic [arsc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    arsc_pkg::arsc_req_s req_q, req_d;
    logic dbl_ok;

    // double trigger only in single or group scan
    assign dbl_ok = i_double_trig && (i_scan_mode == arsc_pkg::SCAN_SINGLE
                                      || i_scan_mode == arsc_pkg::SCAN_GROUP);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        req_d = req_q;
        unique case (st_q)
            arsc_pkg::ARSC_IDLE: begin
                if (i_start) begin
                    st_d = arsc_pkg::ARSC_CONV;
                    cnt_d = '0;
                    req_d = i_req;
                    req_d.second = i_req.second && dbl_ok;
                end
            end
            arsc_pkg::ARSC_CONV: begin
                if (tick) begin
                    if (cnt_q == CONV_CYCLES[arsc_pkg::CNT_W-1:0] - 6'h1) begin
                        st_d = arsc_pkg::ARSC_DONE;
                    end else begin
                        cnt_d = cnt_q + 6'h1;
                    end
                end
            end
            arsc_pkg::ARSC_DONE: begin
                st_d = arsc_pkg::ARSC_IDLE;
            end
            default: st_d = arsc_pkg::ARSC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_q <= arsc_pkg::ARSC_IDLE;
            cnt_q <= '0;
            req_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            req_q <= req_d;
        end
    end

    assign o_busy = (st_q != arsc_pkg::ARSC_IDLE);
    assign o_sample = (st_q == arsc_pkg::ARSC_CONV) && (cnt_q == '0);
    assign o_mux_chan = req_q.chan;
    assign o_mux_src = req_q.src;
    assign o_double_ok = dbl_ok;

    // ***************************************************************
    // result storage
    // ***************************************************************
    logic [arsc_pkg::SUM_W-1:0] chan_q [arsc_pkg::CHANNELS];
    logic [arsc_pkg::SUM_W-1:0] chan_d [arsc_pkg::CHANNELS];
    logic [arsc_pkg::SUM_W-1:0] temp_q, temp_d, ref_q, ref_d, diag_q, diag_d, dup_q, dup_d;
    logic [2:0] acc_n_q, acc_n_d;
    logic [arsc_pkg::SUM_W-1:0] acc_q, acc_d, sum;
    logic done_q, done_d;
    logic fin;

    // registers move only on the completing cycle of their own source
    always_comb begin
        chan_d = chan_q;
        temp_d = temp_q;
        ref_d = ref_q;
        diag_d = diag_q;
        dup_d = dup_q;
        acc_n_d = acc_n_q;
        acc_d = acc_q;
        done_d = 1'b0;
        sum = acc_q + {2'h0, i_sar_data};
        fin = 1'b0;
        if (st_q == arsc_pkg::ARSC_DONE) begin
            unique case (req_q.src)
                arsc_pkg::SRC_TEMP: begin
                    temp_d = {2'h0, i_sar_data};
                    done_d = 1'b1;
                end
                arsc_pkg::SRC_REF: begin
                    ref_d = {2'h0, i_sar_data};
                    done_d = 1'b1;
                end
                arsc_pkg::SRC_DIAG: begin
                    diag_d = {2'h0, i_sar_data};
                    done_d = 1'b1;
                end
                default: begin
                    if (req_q.second) begin
                        dup_d = {2'h0, i_sar_data};
                        done_d = 1'b1;
                    end else if (i_add_mode && !dbl_ok) begin
                        // partial sums stay in acc so the visible register holds until the sum is whole
                        fin = (acc_n_q + 3'h1 >= i_add_count) || (acc_n_q == 3'(arsc_pkg::ADD_MAX - 1));
                        if (fin) begin
                            chan_d[req_q.chan] = sum;
                            acc_d = '0;
                            acc_n_d = 3'h0;
                            done_d = 1'b1;
                        end else begin
                            acc_d = sum;
                            acc_n_d = acc_n_q + 3'h1;
                        end
                    end else begin
                        chan_d[req_q.chan] = {2'h0, i_sar_data};
                        done_d = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int i = 0; i < arsc_pkg::CHANNELS; i++) begin
                chan_q[i] <= '0;
            end
            temp_q <= '0;
            ref_q <= '0;
            diag_q <= '0;
            dup_q <= '0;
            acc_q <= '0;
            acc_n_q <= 3'h0;
            done_q <= 1'b0;
        end else begin
            chan_q <= chan_d;
            temp_q <= temp_d;
            ref_q <= ref_d;
            diag_q <= diag_d;
            dup_q <= dup_d;
            acc_q <= acc_d;
            acc_n_q <= acc_n_d;
            done_q <= done_d;
        end
    end

    assign o_done = done_q;

    // ***************************************************************
    // registered read port
    // ***************************************************************
    arsc_pkg::arsc_rd_s rd_q, rd_d;

    always_comb begin
        rd_d.valid = 1'b1;
        rd_d.data = '0;
        if (i_rd_dup) begin
            rd_d.data = dup_q;
        end else begin
            unique case (i_rd_src)
                arsc_pkg::SRC_TEMP: rd_d.data = temp_q;
                arsc_pkg::SRC_REF: rd_d.data = ref_q;
                arsc_pkg::SRC_DIAG: rd_d.data = diag_q;
                default: begin
                    if (i_rd_chan < arsc_pkg::CH_W'(arsc_pkg::CHANNELS)) begin
                        rd_d.data = chan_q[i_rd_chan];
                    end else begin
                        rd_d.valid = 1'b0;  // no such channel
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rd_q <= '0;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign o_rd = rd_q;
endmodule
`default_nettype wire

// ==== hw/arsc_pkg.sv ====
`default_nettype none
package arsc_pkg;
    // ***************************************************************
    // sizes and timing
    // ***************************************************************
    localparam int CHANNELS = 24;
    localparam int RES_W = 12;
    localparam int SUM_W = 14;
    localparam int CH_W = 5;
    localparam int CONV_NS_X10 = 14000;          // 1.4 us in units of 0.1 ns
    localparam int CONV_CLK_MHZ = 32;
    // cycles per conversion, rounded down: 14000*32/10000 = 44.8 -> 44, plus final latch cycle
    localparam int CONV_CYCLES = (CONV_NS_X10 * CONV_CLK_MHZ) / 10000 + 1;
    localparam int CNT_W = 6;
    localparam int ADD_MAX = 4;                  // largest number of summed results

    // ***************************************************************
    // source select and clock ratio encodings
    // ***************************************************************
    localparam logic [1:0] SRC_CHAN = 2'h0;
    localparam logic [1:0] SRC_TEMP = 2'h1;
    localparam logic [1:0] SRC_REF = 2'h2;
    localparam logic [1:0] SRC_DIAG = 2'h3;

    localparam logic [2:0] RATIO_1_1 = 3'h0;     // bus:conversion clock
    localparam logic [2:0] RATIO_1_2 = 3'h1;
    localparam logic [2:0] RATIO_2_1 = 3'h2;
    localparam logic [2:0] RATIO_4_1 = 3'h3;
    localparam logic [2:0] RATIO_8_1 = 3'h4;

    localparam logic [1:0] SCAN_SINGLE = 2'h0;
    localparam logic [1:0] SCAN_CONT = 2'h1;
    localparam logic [1:0] SCAN_GROUP = 2'h2;

    typedef enum logic [1:0] {
        ARSC_IDLE = 2'b00,
        ARSC_CONV = 2'b01,
        ARSC_DONE = 2'b10
    } arsc_state_e;

    // one conversion request
    typedef struct packed {
        logic [1:0] src;
        logic [CH_W-1:0] chan;
        logic second;        // second trigger of a double-trigger pair
    } arsc_req_s;

    // result read port
    typedef struct packed {
        logic [SUM_W-1:0] data;
        logic valid;
    } arsc_rd_s;
endpackage
`default_nettype wire

// ==== sim/arsc_chk.sv ====
`default_nettype none
module arsc_chk #(parameter int CONV_CYCLES = 4) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [2:0] i_clk_ratio,
    input wire logic [1:0] i_scan_mode,
    input wire logic i_double_trig,
    input wire logic i_start,
    input wire logic o_busy,
    input wire logic o_sample,
    input wire logic [4:0] o_mux_chan,
    input wire logic [1:0] o_mux_src,
    input wire logic o_done,
    input wire logic o_double_ok,
    input wire logic [1:0] i_rd_src,
    input wire logic [4:0] i_rd_chan,
    input wire logic i_rd_dup,
    input wire arsc_pkg::arsc_rd_s o_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // span counter
    // ****
    logic [9:0] cnt_q, cnt_d, lim_q, lim_d;
    // span is latched at take, since the ratio may move mid-run
    always_comb begin
        cnt_d = (cnt_q != 10'h000) ? cnt_q + 10'h001 : 10'h000;
        lim_d = lim_q;
        if (i_start && !o_busy) begin
            cnt_d = 10'h001;
            lim_d = 10'(CONV_CYCLES * (i_clk_ratio == 3'h2 ? 2 : i_clk_ratio == 3'h3 ? 4 :
                i_clk_ratio == 3'h4 ? 8 : 1) + 2);
        end
    end
    always_ff @(posedge i_clk) begin
        cnt_q <= i_srst ? 10'h000 : cnt_d;
        lim_q <= i_srst ? 10'h000 : lim_d;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_take;
        i_start && !o_busy;
    endsequence
    sequence s_sel_hold;
        $stable(i_rd_src) && $stable(i_rd_chan) && $stable(i_rd_dup) && !o_done && !$past(i_srst);
    endsequence
    AST_START: assert property (s_take |=> o_busy && o_sample)
        else $error("start not taken");
    AST_TIME: assert property (o_done |-> cnt_q == lim_q)
        else $error("conversion span wrong");
    AST_DONE_PULSE: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    AST_DONE_IDLE: assert property (o_done |-> !o_busy)
        else $error("busy with done");
    AST_DOUBLE: assert property (o_double_ok == (i_double_trig &&
        (i_scan_mode == arsc_pkg::SCAN_SINGLE || i_scan_mode == arsc_pkg::SCAN_GROUP)))
        else $error("double trigger gating wrong");
    AST_RD_RANGE: assert property (i_rd_src == arsc_pkg::SRC_CHAN && !i_rd_dup |=>
        o_rd.valid == ($past(i_rd_chan) < 5'h18))
        else $error("read valid wrong");
    AST_MUX_HOLD: assert property (o_busy && $past(o_busy) |-> $stable(o_mux_chan) && $stable(o_mux_src))
        else $error("mux moved mid conversion");
    AST_RD_HOLD: assert property (s_sel_hold |=> $stable(o_rd))
        else $error("result moved without done");
endmodule
`default_nettype wire

// ==== sim/arsc_fe_model.sv ====
`default_nettype none
module arsc_fe_model (
    input wire logic i_clk,
    input wire logic i_busy,
    input wire logic [4:0] i_chan,
    input wire logic [1:0] i_src,
    input wire logic [3:0] i_salt,
    output logic [11:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] held_q;
    // value tags its source; released line shows the inverse, not a stale copy
    always_ff @(posedge i_clk) begin
        if (i_busy) begin
            held_q <= {i_salt, i_src, i_chan, 1'b1};
        end
    end
    assign o_data = i_busy ? {i_salt, i_src, i_chan, 1'b1} : ~held_q;
endmodule
`default_nettype wire

// ==== sim/arsc_core_bench.sv ====
`default_nettype none
module arsc_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CC = 4;
    logic clk, srst, dbl, addm, start, busy, sample, done, dok, rdup, poke, dn;
    logic [2:0] ratio, addc;
    logic [1:0] scan, msrc, rsrc;
    logic [4:0] mchan, rchan;
    logic [3:0] salt;
    logic [11:0] sar;
    arsc_pkg::arsc_req_s req;
    arsc_pkg::arsc_rd_s rd;
    int miscompares = 0;
    int comparisons = 0;
    int n;
    int dv[5] = '{1, 1, 2, 4, 8};
    arsc_core #(.CONV_CYCLES(CC)) i_dut (.i_clk(clk), .i_srst(srst), .i_clk_ratio(ratio), .i_scan_mode(scan),
        .i_double_trig(dbl), .i_add_mode(addm), .i_add_count(addc), .i_start(start), .i_req(req), .o_busy(busy),
        .o_sample(sample), .o_mux_chan(mchan), .o_mux_src(msrc), .i_sar_data(sar), .o_done(done),
        .o_double_ok(dok), .i_rd_src(rsrc), .i_rd_chan(rchan), .i_rd_dup(rdup), .o_rd(rd));
    arsc_fe_model i_fe (.i_clk(clk), .i_busy(busy), .i_chan(mchan), .i_src(msrc), .i_salt(salt), .o_data(sar));
    // ****
    // helpers
    // ****
    function automatic logic [14:0] fe(input logic [3:0] a, input logic [1:0] s, input logic [4:0] c);
        return {2'b00, a, s, c, 1'b1, 1'b1};
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one conversion; poke retriggers mid-run to show a busy start is ignored
    task automatic conv(input logic [1:0] s, input logic [4:0] c, input logic sec);
        @(negedge clk);
        req = '{src: s, chan: c, second: sec};
        start = 1'b1;
        @(negedge clk);
        start = poke;
        req.chan = ~c;
        n = 1;
        while (busy === 1'b1 && n < 500) begin
            @(negedge clk);
            start = 1'b0;
            n++;
        end
        if (busy === 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, busy, 1'b0);
        end
        dn = done;
    endtask
    task automatic rdchk(input logic [1:0] s, input logic [4:0] c, input logic d, input logic [14:0] exp);
        @(negedge clk);
        rsrc = s;
        rchan = c;
        rdup = d;
        @(negedge clk);
        cmp(16'(rd), 16'(exp));
    endtask
    // ****
    // scenarios
    // ****
    task automatic sc_ratio();
        for (int r = 0; r < 5; r++) begin
            ratio = 3'(r);
            salt = 4'(r);
            poke = (r == 4);
            conv(arsc_pkg::SRC_CHAN, 5'(r + 3), 1'b0);
            cmp(16'(n), 16'(CC * dv[r] + 2));
            rdchk(arsc_pkg::SRC_CHAN, 5'(r + 3), 1'b0, fe(4'(r), 2'h0, 5'(r + 3)));
        end
        poke = 1'b0;
        rdchk(arsc_pkg::SRC_CHAN, 5'h18, 1'b0, 15'h0000);
        cmp(16'(rd.valid), 16'h0000);
    endtask
    task automatic sc_special();
        salt = 4'h5;
        for (int s = 1; s < 4; s++) begin
            conv(2'(s), 5'h00, 1'b0);
            cmp(16'(dn), 16'h0001);
            rdchk(2'(s), 5'h00, 1'b0, fe(4'h5, 2'(s), 5'h00));
        end
        rdchk(arsc_pkg::SRC_CHAN, 5'h03, 1'b0, fe(4'h0, 2'h0, 5'h03));
    endtask
    task automatic sc_add();
        addm = 1'b1;
        addc = 3'h3;
        for (int k = 0; k < 3; k++) begin
            salt = 4'hD + 4'(k);
            conv(arsc_pkg::SRC_CHAN, 5'h07, 1'b0);
            cmp(16'(dn), 16'(k == 2));
        end
        rdchk(arsc_pkg::SRC_CHAN, 5'h07, 1'b0, {14'h2A2D, 1'b1});
        addm = 1'b0;
    endtask
    task automatic sc_double();
        dbl = 1'b1;
        salt = 4'h1;
        conv(arsc_pkg::SRC_CHAN, 5'h05, 1'b0);
        salt = 4'h2;
        conv(arsc_pkg::SRC_CHAN, 5'h05, 1'b1);
        rdchk(arsc_pkg::SRC_CHAN, 5'h05, 1'b0, fe(4'h1, 2'h0, 5'h05));
        rdchk(arsc_pkg::SRC_CHAN, 5'h05, 1'b1, fe(4'h2, 2'h0, 5'h05));
        scan = arsc_pkg::SCAN_GROUP;
        @(negedge clk);
        cmp(16'(dok), 16'h0001);
        scan = arsc_pkg::SCAN_CONT;
        @(negedge clk);
        cmp(16'(dok), 16'h0000);
        salt = 4'h3;
        conv(arsc_pkg::SRC_CHAN, 5'h05, 1'b1);
        rdchk(arsc_pkg::SRC_CHAN, 5'h05, 1'b0, fe(4'h3, 2'h0, 5'h05));
        rdchk(arsc_pkg::SRC_CHAN, 5'h05, 1'b1, fe(4'h2, 2'h0, 5'h05));
    endtask
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // clock and main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {srst, dbl, addm, start, rdup, poke} = 6'h20;
        {ratio, addc, scan, rsrc, rchan, salt} = '0;
        req = '0;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        sc_ratio();
        sc_special();
        sc_add();
        sc_double();
        test_done();
    end
    // watchdog, far above the roughly 430 cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
endmodule
bind arsc_core arsc_chk #(.CONV_CYCLES(CONV_CYCLES)) i_chk (.i_clk(i_clk), .i_srst(i_srst),
    .i_clk_ratio(i_clk_ratio), .i_scan_mode(i_scan_mode), .i_double_trig(i_double_trig), .i_start(i_start),
    .o_busy(o_busy), .o_sample(o_sample), .o_mux_chan(o_mux_chan), .o_mux_src(o_mux_src), .o_done(o_done),
    .o_double_ok(o_double_ok), .i_rd_src(i_rd_src), .i_rd_chan(i_rd_chan), .i_rd_dup(i_rd_dup), .o_rd(o_rd));
`default_nettype wire
